// File: hdl/dtc_diag.sv
// diagnostic control: pin probe multiplexer, counter modes, misc register
// Notes on behaviour
// - pins are gpio unless own enable set
// - select byte picks probe signal group
// - select 02: frame, 8/4/2 MHz strobes
// - selects 08/10: target and master signals
// - select 40: selector and failback state
// - fallback, commands; select 20 pll locks
// - select 80: stalled, snapping, pll taps
// - low byte of modulo load value
// - upper three modulo bits in high register
// - bit 5 breaks counter carry chains
// - bit 4 uses external frame compare
// - bit 3 enables early modulo rollover
// - misc bit 5 shortens discard timers
// - misc bit 4 opens bridge registers
// - misc bit 3 opens channel memory
// - misc bit 2 resets pll two divider
// - misc bit 1 resets pll one divider
// - misc bit 0 drives por test input
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/100ps
`include "dtc_params.svh"
module dtc_diag (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [19:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // general purpose pins
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_oe,
  input wire logic [7:0] gen_purpose_pins_in,
  output logic [7:0] gen_purpose_pins_out,
  output logic [7:0] gen_purpose_pins_oe,
  output logic [7:0] gpio_in,
  // probe sources, group 01 and 02
  input wire logic [3:0] byte_reference_16,
  input wire logic comp_port_8mhz_rd,
  input wire logic comp_port_8mhz_wr,
  input wire logic comp_port_4mhz_rd,
  input wire logic comp_port_4mhz_wr,
  input wire logic comp_port_2mhz_rd,
  input wire logic comp_port_2mhz_wr,
  // probe sources, target and master transfer
  input wire logic target_cmd_valid,
  input wire logic target_retry_forced,
  input wire logic [4:0] target_transmit_fifo,
  input wire logic master_dma_begin,
  input wire logic host_xfer_done,
  input wire logic host_xfer_fault,
  input wire logic [4:0] master_transmit_fifo,
  // probe sources, clocking
  input wire logic digital_pll_two_lock,
  input wire logic digital_pll_one_lock,
  input wire logic primary_secondary_sel,
  input wire logic [2:0] failback_state,
  input wire logic fallback_flag,
  input wire logic [2:0] clock_cmd_ind,
  input wire logic stalled,
  input wire logic snapping,
  input wire logic phase_align_frame,
  input wire logic [2:0] analog_pll_one_taps,
  // frame sources
  input wire logic int_frame,
  input wire logic frame_compare_in_b,
  // diagnostic controls
  output logic carry_break_en,
  output logic ext_frame_select,
  output logic modulo_count_en,
  output logic frame_used,
  output dtc_pkg::dtc_count_t state_count,
  output logic discard_timer_short,
  output logic bridge_regs_access_en,
  output logic chan_mem_access_en,
  output logic pll_two_div_reset,
  output logic pll_one_div_reset,
  output logic por_test_input
);
  import dtc_pkg::*;

  logic rst_meta_b;
  logic rst_sync_b;
  dtc_byte_t pin_probe_enable_reg;
  dtc_byte_t pin_probe_select_reg;
  dtc_byte_t counter_modulo_low_reg;
  dtc_byte_t counter_modes_high_reg;
  dtc_byte_t misc_diagnostics_low_reg;
  dtc_byte_t pin_probe_enable_next;
  dtc_byte_t pin_probe_select_next;
  dtc_byte_t counter_modulo_low_next;
  dtc_byte_t counter_modes_high_next;
  dtc_byte_t misc_diagnostics_low_next;
  dtc_bus_e bus_reg;
  logic [19:0] addr_reg;
  logic [19:0] addr_index;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  dtc_byte_t probe;
  dtc_byte_t grp_byteref;
  dtc_byte_t grp_frame;
  dtc_byte_t grp_target;
  dtc_byte_t grp_master;
  dtc_byte_t grp_lock;
  dtc_byte_t grp_failback;
  dtc_byte_t grp_stall;
  dtc_count_t modulo_load;
  logic take;

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // address phase capture
  // byte address is four times the register offset
  assign addr_index = {2'b00, haddr[19:2]};
  assign take = hsel && hready && htrans[1];

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      bus_reg <= DTC_BUS_IDLE;
      addr_reg <= 20'h0_0000;
    end else if (hready) begin
      if (take) begin
        bus_reg <= hwrite ? DTC_BUS_WRITE : DTC_BUS_READ;
        addr_reg <= addr_index;
      end else begin
        bus_reg <= DTC_BUS_IDLE;
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // next register values, a write lands at the end of its data phase
  always_comb begin
    pin_probe_enable_next = pin_probe_enable_reg;
    pin_probe_select_next = pin_probe_select_reg;
    counter_modulo_low_next = counter_modulo_low_reg;
    counter_modes_high_next = counter_modes_high_reg;
    misc_diagnostics_low_next = misc_diagnostics_low_reg;
    if (bus_reg == DTC_BUS_WRITE) begin
      case (addr_reg)
        `DTC_OFS_PIN_PROBE_EN: begin
          pin_probe_enable_next = hwdata[7:0];
        end
        `DTC_OFS_PIN_PROBE_SEL: begin
          pin_probe_select_next = hwdata[7:0];
        end
        `DTC_OFS_MOD_LOW: begin
          counter_modulo_low_next = hwdata[7:0];
        end
        `DTC_OFS_MODES_HIGH: begin
          counter_modes_high_next = hwdata[7:0] & `DTC_MODES_HIGH_MASK;
        end
        `DTC_OFS_MISC_LOW: begin
          misc_diagnostics_low_next = hwdata[7:0] & `DTC_MISC_LOW_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pin_probe_enable_reg <= `DTC_RST_BYTE;
      pin_probe_select_reg <= `DTC_RST_BYTE;
      counter_modulo_low_reg <= `DTC_RST_BYTE;
      counter_modes_high_reg <= `DTC_RST_BYTE;
      misc_diagnostics_low_reg <= `DTC_RST_BYTE;
    end else begin
      pin_probe_enable_reg <= pin_probe_enable_next;
      pin_probe_select_reg <= pin_probe_select_next;
      counter_modulo_low_reg <= counter_modulo_low_next;
      counter_modes_high_reg <= counter_modes_high_next;
      misc_diagnostics_low_reg <= misc_diagnostics_low_next;
    end
  end

  // read data from a flop, taken at the address phase; a pending write is forwarded
  always_comb begin
    hrdata_next = 32'h0000_0000;
    if (take && !hwrite) begin
      case (addr_index)
        `DTC_OFS_PIN_PROBE_EN: hrdata_next = {24'h00_0000, pin_probe_enable_next};
        `DTC_OFS_PIN_PROBE_SEL: hrdata_next = {24'h00_0000, pin_probe_select_next};
        `DTC_OFS_MOD_LOW: hrdata_next = {24'h00_0000, counter_modulo_low_next};
        `DTC_OFS_MODES_HIGH: hrdata_next = {24'h00_0000, counter_modes_high_next};
        `DTC_OFS_MISC_LOW: hrdata_next = {24'h00_0000, misc_diagnostics_low_next};
        `DTC_OFS_COUNTER_STATE: hrdata_next = {21'h0_0000, state_count};
        default: hrdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (hready) begin
      hrdata_reg <= hrdata_next;
    end
  end

  assign hrdata = hrdata_reg;

  // control outputs
  assign carry_break_en = counter_modes_high_reg[`DTC_BIT_CARRY_BREAK];
  assign ext_frame_select = counter_modes_high_reg[`DTC_BIT_EXT_FRAME];
  assign modulo_count_en = counter_modes_high_reg[`DTC_BIT_MODULO_EN];
  assign modulo_load = {counter_modes_high_reg[2:0], counter_modulo_low_reg};
  assign discard_timer_short = misc_diagnostics_low_reg[`DTC_BIT_DISCARD_SHORT];
  assign bridge_regs_access_en = misc_diagnostics_low_reg[`DTC_BIT_BRIDGE_EN];
  assign chan_mem_access_en = misc_diagnostics_low_reg[`DTC_BIT_CHAN_MEM_EN];
  assign pll_two_div_reset = misc_diagnostics_low_reg[`DTC_BIT_PLL_TWO_RST];
  assign pll_one_div_reset = misc_diagnostics_low_reg[`DTC_BIT_PLL_ONE_RST];
  assign por_test_input = misc_diagnostics_low_reg[`DTC_BIT_POR_TEST];

  dtc_state_counter u_counter (
    .clk(clk),
    .rst_sync_b(rst_sync_b),
    .int_frame(int_frame),
    .frame_compare_in_b(frame_compare_in_b),
    .carry_break_en(carry_break_en),
    .ext_frame_select(ext_frame_select),
    .modulo_count_en(modulo_count_en),
    .modulo_load(modulo_load),
    .count(state_count),
    .frame_used(frame_used)
  );

  // probe groups, one bit per pin, reserved positions tied low
  // select 01: byte reference and low count
  assign grp_byteref[7] = byte_reference_16[3];
  assign grp_byteref[6] = byte_reference_16[2];
  assign grp_byteref[5] = byte_reference_16[1];
  assign grp_byteref[4] = byte_reference_16[0];
  assign grp_byteref[3] = state_count[3];
  assign grp_byteref[2] = state_count[2];
  assign grp_byteref[1] = state_count[1];
  assign grp_byteref[0] = state_count[0];

  // select 02: frame and port strobes
  assign grp_frame[7] = frame_used;
  assign grp_frame[6] = 1'b0;
  assign grp_frame[5] = comp_port_8mhz_rd;
  assign grp_frame[4] = comp_port_8mhz_wr;
  assign grp_frame[3] = comp_port_4mhz_rd;
  assign grp_frame[2] = comp_port_4mhz_wr;
  assign grp_frame[1] = comp_port_2mhz_rd;
  assign grp_frame[0] = comp_port_2mhz_wr;

  // select 08: target side transfer
  assign grp_target[7] = target_cmd_valid;
  assign grp_target[6] = target_retry_forced;
  assign grp_target[5] = 1'b0;
  assign grp_target[4] = target_transmit_fifo[4];
  assign grp_target[3] = target_transmit_fifo[3];
  assign grp_target[2] = target_transmit_fifo[2];
  assign grp_target[1] = target_transmit_fifo[1];
  assign grp_target[0] = target_transmit_fifo[0];

  // select 10: master side transfer
  assign grp_master[7] = master_dma_begin;
  assign grp_master[6] = host_xfer_done;
  assign grp_master[5] = host_xfer_fault;
  assign grp_master[4] = master_transmit_fifo[4];
  assign grp_master[3] = master_transmit_fifo[3];
  assign grp_master[2] = master_transmit_fifo[2];
  assign grp_master[1] = master_transmit_fifo[1];
  assign grp_master[0] = master_transmit_fifo[0];

  // select 20: digital pll locks
  assign grp_lock[7] = digital_pll_two_lock;
  assign grp_lock[6] = digital_pll_one_lock;
  assign grp_lock[5] = 1'b0;
  assign grp_lock[4] = 1'b0;
  assign grp_lock[3] = 1'b0;
  assign grp_lock[2] = 1'b0;
  assign grp_lock[1] = 1'b0;
  assign grp_lock[0] = 1'b0;

  // select 40: reference selection and failback
  assign grp_failback[7] = primary_secondary_sel;
  assign grp_failback[6] = failback_state[2];
  assign grp_failback[5] = failback_state[1];
  assign grp_failback[4] = failback_state[0];
  assign grp_failback[3] = fallback_flag;
  assign grp_failback[2] = clock_cmd_ind[2];
  assign grp_failback[1] = clock_cmd_ind[1];
  assign grp_failback[0] = clock_cmd_ind[0];

  // select 80: stall, snap and analog pll taps
  assign grp_stall[7] = stalled;
  assign grp_stall[6] = snapping;
  assign grp_stall[5] = 1'b0;
  assign grp_stall[4] = 1'b0;
  assign grp_stall[3] = phase_align_frame;
  assign grp_stall[2] = analog_pll_one_taps[2];
  assign grp_stall[1] = analog_pll_one_taps[1];
  assign grp_stall[0] = analog_pll_one_taps[0];

  // probe group select
  always_comb begin
    case (pin_probe_select_reg)
      8'h01: probe = grp_byteref;
      8'h02: probe = grp_frame;
      8'h08: probe = grp_target;
      8'h10: probe = grp_master;
      8'h20: probe = grp_lock;
      8'h40: probe = grp_failback;
      8'h80: probe = grp_stall;
      default: probe = 8'h00;
    endcase
  end

  // per pin gpio or probe, probe output registered
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      logic probe_q;
      always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          probe_q <= 1'b0;
        end else begin
          probe_q <= probe[gi];
        end
      end
      assign gen_purpose_pins_out[gi] = pin_probe_enable_reg[gi] ? probe_q : gpio_out[gi];
      assign gen_purpose_pins_oe[gi] = pin_probe_enable_reg[gi] | gpio_oe[gi];
      assign gpio_in[gi] = gen_purpose_pins_in[gi];
    end
  endgenerate
endmodule : dtc_diag

// File: hdl/dtc_params.svh
// register offsets, field positions and reset values for the diagnostic block
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

`define DTC_OFS_PIN_PROBE_EN 20'h0_0142
`define DTC_OFS_PIN_PROBE_SEL 20'h0_0143
`define DTC_OFS_MOD_LOW 20'h0_0144
`define DTC_OFS_MODES_HIGH 20'h0_0145
`define DTC_OFS_MISC_LOW 20'h0_0146
`define DTC_OFS_COUNTER_STATE 20'h0_0150

`define DTC_BIT_CARRY_BREAK 5
`define DTC_BIT_EXT_FRAME 4
`define DTC_BIT_MODULO_EN 3
`define DTC_BIT_DISCARD_SHORT 5
`define DTC_BIT_BRIDGE_EN 4
`define DTC_BIT_CHAN_MEM_EN 3
`define DTC_BIT_PLL_TWO_RST 2
`define DTC_BIT_PLL_ONE_RST 1
`define DTC_BIT_POR_TEST 0

`define DTC_RST_BYTE 8'h00
`define DTC_MODES_HIGH_MASK 8'h3f
`define DTC_MISC_LOW_MASK 8'h3f

`define DTC_CNT_LAST 11'h7_ff

`endif

// File: hdl/dtc_pkg.sv
// types shared by the diagnostic block
package dtc_pkg;
  typedef logic [7:0] dtc_byte_t;
  typedef logic [10:0] dtc_count_t;
  typedef enum logic [1:0] {
    DTC_BUS_IDLE = 2'b00,
    DTC_BUS_WRITE = 2'b01,
    DTC_BUS_READ = 2'b10
  } dtc_bus_e;
endpackage : dtc_pkg

// File: hdl/dtc_state_counter.sv
// 11-bit state counter with diagnostic carry break, frame override and modulo
`timescale 1ns/100ps
`include "dtc_params.svh"
module dtc_state_counter (
  // clock and reset
  input wire logic clk,
  input wire logic rst_sync_b,
  // frame sources
  input wire logic int_frame,
  input wire logic frame_compare_in_b,
  // modes
  input wire logic carry_break_en,
  input wire logic ext_frame_select,
  input wire logic modulo_count_en,
  input wire dtc_pkg::dtc_count_t modulo_load,
  // outputs
  output dtc_pkg::dtc_count_t count,
  output logic frame_used
);
  import dtc_pkg::*;

  dtc_count_t count_reg;
  dtc_count_t count_next;
  logic [2:0] hi_next;
  logic [3:0] mid_next;
  logic [3:0] lo_next;
  logic frame_sel;

  // frame compare pin is active low
  assign frame_sel = ext_frame_select ? ~frame_compare_in_b : int_frame;

  always_comb begin
    lo_next = count_reg[3:0] + 4'h1;
    mid_next = count_reg[7:4];
    hi_next = count_reg[10:8];
    if (carry_break_en) begin
      // three pieces each count on every clock
      mid_next = count_reg[7:4] + 4'h1;
      hi_next = count_reg[10:8] + 3'h1;
    end else begin
      if (count_reg[3:0] == 4'hf) begin
        mid_next = count_reg[7:4] + 4'h1;
        if (count_reg[7:4] == 4'hf) begin
          hi_next = count_reg[10:8] + 3'h1;
        end
      end
    end
    count_next = {hi_next, mid_next, lo_next};
    if (frame_sel) begin
      count_next = 11'h0_00;
    end else if (modulo_count_en && (count_reg == modulo_load)) begin
      count_next = 11'h0_00;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      count_reg <= 11'h0_00;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;
  assign frame_used = frame_sel;
endmodule : dtc_state_counter

// File: bench/dtc_diag_chk.sv
// port checker for the diagnostic block
`timescale 1ns/100ps
module dtc_diag_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // pins
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_oe,
  input wire logic [7:0] gen_purpose_pins_in,
  input wire logic [7:0] gen_purpose_pins_out,
  input wire logic [7:0] gen_purpose_pins_oe,
  input wire logic [7:0] gpio_in,
  // counter
  input wire logic int_frame,
  input wire logic frame_compare_in_b,
  input wire logic carry_break_en,
  input wire logic ext_frame_select,
  input wire logic modulo_count_en,
  input wire logic frame_used,
  input wire dtc_pkg::dtc_count_t state_count
);
  import dtc_pkg::*;
  logic [1:0] live_reg;
  // counter lags reset release by the sync flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      live_reg <= 2'h0;
    end else if (live_reg != 2'h3) begin
      live_reg <= live_reg + 2'h1;
    end
  end
  wire logic run = (live_reg == 2'h3);
  wire logic free = run && !frame_used;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_OKAY: assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
  AST_PIN_OE: assert property ((gpio_oe & ~gen_purpose_pins_oe) == 8'h00)
    else $error("pin enable lost gpio drive");
  AST_PIN_GPIO: assert property (((gen_purpose_pins_out ^ gpio_out) & ~gen_purpose_pins_oe) == 8'h00)
    else $error("gpio pin not passed through");
  AST_PIN_IN: assert property (gpio_in == gen_purpose_pins_in)
    else $error("pin input not returned");
  AST_FRAME_SRC: assert property (frame_used == (ext_frame_select ? !frame_compare_in_b : int_frame))
    else $error("wrong frame source");
  AST_FRAME_CLR: assert property (run && frame_used |=> state_count == 11'h000)
    else $error("frame did not clear counter");
  AST_COUNT_INC: assert property (free && !carry_break_en && !modulo_count_en |=> state_count == $past(state_count) + 11'h001)
    else $error("counter did not step");
  AST_CARRY_BRK: assert property (free && carry_break_en && !modulo_count_en |=> state_count[3:0] == $past(state_count[3:0]) + 4'h1 && state_count[7:4] == $past(state_count[7:4]) + 4'h1 && state_count[10:8] == $past(state_count[10:8]) + 3'h1)
    else $error("counter pieces did not step alone");
  AST_MODULO: assert property (free && modulo_count_en && !carry_break_en |=> state_count == 11'h000 || state_count == $past(state_count) + 11'h001)
    else $error("modulo count jumped");
  cover property (free && carry_break_en);
  cover property (free && modulo_count_en ##1 state_count == 11'h000);
  cover property (ext_frame_select && frame_used);
endmodule : dtc_diag_chk
bind dtc_diag dtc_diag_chk u_chk (.*);

// File: bench/diag_testpoint_and_counter_modes_tb_top.sv
// self-checking bench for the diagnostic block
`timescale 1ns/100ps
`include "dtc_params.svh"
module diag_testpoint_and_counter_modes_tb_top;
  import dtc_pkg::*;
  localparam logic [19:0] A_EN = `DTC_OFS_PIN_PROBE_EN << 2;
  localparam logic [19:0] A_SEL = `DTC_OFS_PIN_PROBE_SEL << 2;
  localparam logic [19:0] A_LOW = `DTC_OFS_MOD_LOW << 2;
  localparam logic [19:0] A_HIGH = `DTC_OFS_MODES_HIGH << 2;
  localparam logic [19:0] A_MISC = `DTC_OFS_MISC_LOW << 2;
  localparam logic [19:0] A_NONE = 20'h0_051c;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [19:0] haddr = 20'h0_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [64:0] s = '0;
  logic int_frame = 1'b0;
  logic fcb = 1'b1;
  logic [31:0] hrdata, rd, lo, hi, mi;
  logic hreadyout, hresp, hit;
  logic [7:0] pout, poe, sl, en;
  logic [8:0] ctl;
  logic [3:0] nib;
  dtc_count_t cnt;
  int n_errors = 0;
  int total_checks = 0;
  logic [19:0] ad [6] = '{A_EN, A_SEL, A_LOW, A_HIGH, A_MISC, A_NONE};
  logic [7:0] sels [10] = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h04, 8'h03, 8'h00};
  dtc_diag dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .int_frame(int_frame), .hsize(3'h2), .hready(hreadyout), .gpio_out(s[48:41]),
    .gpio_oe(s[56:49]),
    .gen_purpose_pins_in(s[64:57]), .gen_purpose_pins_out(pout), .gen_purpose_pins_oe(poe),
    .gpio_in(), .byte_reference_16(s[3:0]), .comp_port_2mhz_wr(s[4]), .comp_port_2mhz_rd(s[5]),
    .comp_port_4mhz_wr(s[6]), .comp_port_4mhz_rd(s[7]), .comp_port_8mhz_wr(s[8]),
    .comp_port_8mhz_rd(s[9]), .target_transmit_fifo(s[14:10]), .target_retry_forced(s[15]),
    .target_cmd_valid(s[16]), .master_transmit_fifo(s[21:17]), .host_xfer_fault(s[22]),
    .host_xfer_done(s[23]), .master_dma_begin(s[24]), .digital_pll_one_lock(s[25]),
    .digital_pll_two_lock(s[26]), .clock_cmd_ind(s[29:27]), .fallback_flag(s[30]),
    .failback_state(s[33:31]), .primary_secondary_sel(s[34]), .analog_pll_one_taps(s[37:35]),
    .phase_align_frame(s[38]), .snapping(s[39]), .stalled(s[40]), .frame_compare_in_b(fcb),
    .carry_break_en(ctl[8]), .ext_frame_select(ctl[7]), .modulo_count_en(ctl[6]),
    .discard_timer_short(ctl[5]), .bridge_regs_access_en(ctl[4]), .chan_mem_access_en(ctl[3]),
    .pll_two_div_reset(ctl[2]), .pll_one_div_reset(ctl[1]), .por_test_input(ctl[0]),
    .frame_used(), .state_count(cnt));
  always #4 clk = ~clk;
  function automatic logic [7:0] ep(input logic [7:0] k, input logic [64:0] v, input logic f,
    input logic [3:0] c);
    case (k)
      8'h01: ep = {v[3:0], c};
      8'h02: ep = {f, 1'b0, v[9:4]};
      8'h08: ep = {v[16:15], 1'b0, v[14:10]};
      8'h10: ep = v[24:17];
      8'h20: ep = {v[26:25], 6'h00};
      8'h40: ep = v[34:27];
      8'h80: ep = {v[40:39], 2'h0, v[38:35]};
      default: ep = 8'h00;
    endcase
  endfunction : ep
  task automatic final_report();
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wait_rdy();
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      if (hreadyout === 1'b1) begin
        rd = hrdata;
        @(posedge clk);
        return;
      end
    end
    n_errors++;
    final_report();
  endtask : wait_rdy
  task automatic xfer(input logic w, input logic [19:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask : xfer
  initial begin
    void'($urandom(88));
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    chk("controls at reset", 32'h0, ctl);
    foreach (ad[k]) begin
      xfer(1'b0, ad[k], 32'h0);
      chk("reset read", 32'h0, rd);
    end
    for (int k = 0; k < 8; k++) begin
      lo = (k == 0) ? 32'hffff_ffff : $urandom();
      hi = (k == 0) ? 32'hffff_ffff : $urandom();
      mi = (k == 0) ? 32'hffff_ffff : $urandom();
      xfer(1'b1, A_LOW, lo);
      xfer(1'b1, A_HIGH, hi);
      xfer(1'b1, A_MISC, mi);
      xfer(1'b1, A_NONE, 32'hffff_ffff);
      xfer(1'b0, A_LOW, 32'h0);
      chk("modulo low", {24'h0, lo[7:0]}, rd);
      xfer(1'b0, A_HIGH, 32'h0);
      chk("modes high", {26'h0, hi[5:0]}, rd);
      xfer(1'b0, A_MISC, 32'h0);
      chk("misc", {26'h0, mi[5:0]}, rd);
      xfer(1'b0, A_NONE, 32'h0);
      chk("unmapped", 32'h0, rd);
      chk("controls", {hi[5:3], mi[5:0]}, ctl);
    end
    xfer(1'b1, A_LOW, 32'h5);
    xfer(1'b1, A_HIGH, 32'h18);
    fcb <= 1'b0;
    @(posedge clk);
    fcb <= 1'b1;
    @(negedge clk);
    chk("frame clear", 32'h0, cnt);
    hit = 1'b0;
    repeat (24) begin
      @(negedge clk);
      chk("count bound", 32'h1, cnt <= 11'h005);
      hit |= (cnt == 11'h005);
    end
    chk("count reached load", 32'h1, hit);
    xfer(1'b1, A_HIGH, 32'h0);
    for (int k = 0; k < 30; k++) begin
      sl = sels[k % 10];
      en = (k < 10) ? 8'hff : 8'($urandom());
      xfer(1'b1, A_SEL, sl);
      xfer(1'b1, A_EN, en);
      s <= 65'({$urandom(), $urandom(), $urandom()});
      int_frame <= 1'($urandom());
      repeat (2) @(posedge clk);
      @(negedge clk);
      nib = int_frame ? 4'h0 : 4'(cnt[3:0] - 4'h1);
      chk("probe pins", (en & ep(sl, s, int_frame, nib)) | (~en & s[48:41]), pout);
      chk("probe oe", en | s[56:49], poe);
      @(posedge clk);
    end
    final_report();
  end
endmodule : diag_testpoint_and_counter_modes_tb_top
